// [verilog/cal_ctrl_pkg.sv]
// constants and carrier types for the converter calibration control block
// assumes a single 250 MHz system clock and an Avalon-MM register bus
package cal_ctrl_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_RUN  = 8'h61;
  localparam logic [7:0] IDX_MODE = 8'h62;
  localparam logic [7:0] IDX_REF  = 8'h65;
  localparam logic [7:0] IDX_STAT = 8'h70;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_RUN  = 8'h01;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_REF  = 8'h01;

  // ==========================================================================
  // field positions
  localparam int RUN_BIT   = 0;
  localparam int FG_BIT    = 0;
  localparam int BG_BIT    = 1;
  localparam int OS_BIT    = 2;
  localparam int BGOS_BIT  = 3;
  localparam int OFFSET_REFERENCE_SELECT_BIT = 2;
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_STATE_LSB = 4;

  // configuration handed to the calibration engine
  typedef struct packed {
    logic fg;
    logic bg;
    logic fg_os;
    logic bg_os;
    logic os_ref_spare;
  } cal_cfg_t;

  // engine sequence states
  typedef enum logic [2:0] {
    S_HELD,
    S_CLEAR,
    S_FOREGROUND,
    S_BACKGROUND,
    S_DONE
  } cal_state_t;

endpackage

// [verilog/adc_calibration_control.sv]
// calibration control: run bit, mode and offset reference registers,
// the engine sequence and the divider reset
// assumes all inputs synchronous to sys_clk_i; the engine reports fg_done_i
//
// What this block does
// - With the run bit high calibration runs, with it low the engine is held in reset; it resets to 1.
// - Clearing the run bit also resets the digital block and serial link clock dividers.
// - Mode bit 3 enables background offset calibration, effective only with background calibration on.
// - Mode bit 2 enables foreground offset calibration, effective only with foreground calibration on.
// - Mode bit 1 enables background calibration; it resets to 0.
// - Mode bit 0 (default 1) clears stored values then runs the foreground pass; at 0 it clears and skips.
// - Reference bit 2 at 0 makes offset calibration use mid-code, aiming at zero offset.
// - Reference bit 2 at 1 makes offset calibration match the spare converter's samples.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module adc_calibration_control #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_b_i,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]      avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // device side
  input  wire logic                   serial_link_enable_i,
  input  wire logic                   fg_done_i,
  output cal_ctrl_pkg::cal_cfg_t      cal_cfg_o,
  output logic                        engine_rst_o,
  output logic                        divider_rst_o,
  output logic                        clear_values_o,
  output logic                        fg_run_o,
  output logic                        bg_run_o,
  output logic                        cal_done_o
);
  import cal_ctrl_pkg::*;

  // ==========================================================================
  // bus slave
  logic             ack_q;
  logic             req;
  logic             aligned;
  logic [7:0]       idx;
  logic             wr_en;
  logic             wr_run;
  logic             wr_mode;
  logic             wr_ref;
  logic             wr_stat;
  logic [31:0]      rd_mux;
  logic [31:0]      rdata_q;

  // every access takes two edges: the first latches read data or commits the write, the second ends it
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign aligned           = (avs_address_i[1:0] == 2'b00);
  assign idx               = avs_address_i[9:2];
  assign wr_en   = avs_write_i & ~ack_q & aligned & avs_byteenable_i[0];
  assign wr_run  = wr_en & (idx == IDX_RUN);
  assign wr_mode = wr_en & (idx == IDX_MODE);
  assign wr_ref  = wr_en & (idx == IDX_REF);
  assign wr_stat = wr_en & (idx == IDX_STAT);

  // ==========================================================================
  // registers
  logic [7:0]       run_q;
  logic [7:0]       mode_q;
  logic [7:0]       ref_q;
  logic             fault_q;
  logic             done_q;
  cal_state_t       state_q;
  cal_state_t       state_d;
  cal_cfg_t         cfg_q;
  cal_cfg_t         cfg_d;
  logic             run_fall;
  logic [7:0]       stat_byte;

  // reserved bits are stored as written; the engine only looks at the fields
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q  <= RST_RUN;
      mode_q <= RST_MODE;
      ref_q  <= RST_REF;
    end else begin
      if (wr_run) begin
        run_q  <= avs_writedata_i[7:0];
      end
      if (wr_mode) begin
        mode_q <= avs_writedata_i[7:0];
      end
      if (wr_ref) begin
        ref_q  <= avs_writedata_i[7:0];
      end
    end
  end

  // ==========================================================================
  // link order watch: run bit cleared while the link was still enabled
  assign run_fall = wr_run & run_q[RUN_BIT] & ~avs_writedata_i[RUN_BIT];

  // a new fault in the clearing cycle wins over the write-one clear
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_q <= 1'b0;
    end else if (run_fall & serial_link_enable_i) begin
      fault_q <= 1'b1;
    end else if (wr_stat & avs_writedata_i[STAT_FAULT_BIT]) begin
      fault_q <= 1'b0;
    end
  end

  // ==========================================================================
  // read path
  assign stat_byte = {1'b0, state_q, 2'b00, fault_q, done_q};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (aligned) begin
      case (idx)
        IDX_RUN:  rd_mux = {24'h00_0000, run_q};
        IDX_MODE: rd_mux = {24'h00_0000, mode_q};
        IDX_REF:  rd_mux = {24'h00_0000, ref_q};
        IDX_STAT: rd_mux = {24'h00_0000, stat_byte};
        default:  rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // unmapped reads return zero, unmapped writes are dropped
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read_i & ~ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign avs_readdata_o = rdata_q;

  // ==========================================================================
  // configuration shadow
  // offset modes are gated by their parent pass so a stray bit cannot start
  // an offset loop with no calibration pass underneath it
  always_comb begin
    cfg_d.fg           = mode_q[FG_BIT];
    cfg_d.bg           = mode_q[BG_BIT];
    cfg_d.fg_os        = mode_q[OS_BIT] & mode_q[FG_BIT];
    cfg_d.bg_os        = mode_q[BGOS_BIT] & mode_q[BG_BIT];
    cfg_d.os_ref_spare = ref_q[OFFSET_REFERENCE_SELECT_BIT];
  end

  // the shadow only follows the registers while the engine is held, so a
  // write during a run cannot disturb the sequence in flight
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q <= '0;
    end else if (state_q == S_HELD) begin
      cfg_q <= cfg_d;
    end
  end

  assign cal_cfg_o = cfg_q;

  // ==========================================================================
  // sequence
  always_comb begin
    state_d = state_q;
    if (!run_q[RUN_BIT]) begin
      state_d = S_HELD;
    end else begin
      case (state_q)
        S_HELD: begin
          state_d = S_CLEAR;
        end
        S_CLEAR: begin
          if (cfg_q.fg) begin
            state_d = S_FOREGROUND;
          end else if (cfg_q.bg) begin
            state_d = S_BACKGROUND;
          end else begin
            state_d = S_DONE;
          end
        end
        S_FOREGROUND: begin
          if (fg_done_i) begin
            state_d = cfg_q.bg ? S_BACKGROUND : S_DONE;
          end
        end
        S_BACKGROUND: begin
          state_d = S_BACKGROUND;
        end
        S_DONE: begin
          state_d = S_DONE;
        end
        default: begin
          state_d = S_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= S_HELD;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q  <= (state_d == S_DONE) | (state_d == S_BACKGROUND);
    end
  end

  // ==========================================================================
  // engine controls
  // dividers share the hold with the engine; the link must already be off
  assign engine_rst_o   = ~run_q[RUN_BIT];
  assign divider_rst_o  = ~run_q[RUN_BIT];
  assign clear_values_o = (state_q == S_CLEAR);
  assign fg_run_o       = (state_q == S_FOREGROUND);
  assign bg_run_o       = (state_q == S_BACKGROUND);
  assign cal_done_o     = done_q;

  // ==========================================================================
  // checks
  property p_hold_low;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      !run_q[RUN_BIT] |-> engine_rst_o ##1 (state_q == S_HELD);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("engine not held with run low");

  property p_div_rst;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      $fell(run_q[RUN_BIT]) |-> divider_rst_o ##1 (divider_rst_o || run_q[RUN_BIT]) && !fg_run_o && !bg_run_o;
  endproperty
  a_div_rst: assert property (p_div_rst) else $error("dividers not reset on run clear");

  property p_bgos_gate;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == S_HELD) |=> cal_cfg_o.bg_os == ($past(mode_q[BGOS_BIT]) && $past(mode_q[BG_BIT]));
  endproperty
  a_bgos_gate: assert property (p_bgos_gate) else $error("bg offset on without bg");

  property p_fgos_gate;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == S_HELD) |=> cal_cfg_o.fg_os == ($past(mode_q[OS_BIT]) && $past(mode_q[FG_BIT]));
  endproperty
  a_fgos_gate: assert property (p_fgos_gate) else $error("fg offset on without fg");

  property p_start_clear;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == S_HELD) && run_q[RUN_BIT] |=> clear_values_o;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("no value clear at start");

  property p_fg_pass;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      clear_values_o && run_q[RUN_BIT] |=> (fg_run_o == cal_cfg_o.fg) && !clear_values_o;
  endproperty
  a_fg_pass: assert property (p_fg_pass) else $error("fg pass not as configured");

  property p_bg_after_fg;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      fg_run_o && fg_done_i && run_q[RUN_BIT] |=> (bg_run_o == cal_cfg_o.bg) && cal_done_o;
  endproperty
  a_bg_after_fg: assert property (p_bg_after_fg) else $error("bg pass not as configured");

  property p_ref_latch;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == S_HELD) |=> cal_cfg_o.os_ref_spare == $past(ref_q[OFFSET_REFERENCE_SELECT_BIT]);
  endproperty
  a_ref_latch: assert property (p_ref_latch) else $error("offset reference not latched");

  property p_cfg_frozen;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q != S_HELD) |=> $stable(cal_cfg_o);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("settings changed during run");

  property p_fault;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      run_fall && serial_link_enable_i |=> fault_q;
  endproperty
  a_fault: assert property (p_fault) else $error("link order fault lost");

endmodule

`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the calibration control block
// assumes the slave answers within 20 cycles: each request waits for waitrequest low; no partner model
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import cal_ctrl_pkg::*;

  // ==========================================================================
  // stimulus and observed signals
  logic        sys_clk, rst_b, rd, wr, link, fg_done, wait_s;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  cal_cfg_t    cfg;
  logic        eng_rst, div_rst, clr, fg_run, bg_run, done, waitreq;
  int          err_count, checks;

  adc_calibration_control DUT (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .serial_link_enable_i(link), .fg_done_i(fg_done), .cal_cfg_o(cfg),
    .engine_rst_o(eng_rst), .divider_rst_o(div_rst), .clear_values_o(clr),
    .fg_run_o(fg_run), .bg_run_o(bg_run), .cal_done_o(done));

  // ==========================================================================
  // clock, and waitrequest as it stands just before each rising edge
  always #2 sys_clk = ~sys_clk;
  always @(negedge sys_clk) wait_s <= waitreq;

  // ==========================================================================
  // compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // one request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    addr  <= a;
    wr    <= w;
    rd    <= ~w;
    wdata <= {24'h0, d};
    be    <= b;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wait_s !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0);
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, {idx, 2'b00}, d, 4'hF, q);
  endtask

  task automatic rreg(input logic [9:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'hF, q);
    chk(q, {24'h0, exp});
  endtask

  // raise the run bit, follow the sequence and judge the outcome
  task automatic run_seq(input logic [4:0] ecfg);
    int n, nclr;
    nclr = 0;
    wreg(IDX_RUN, 8'h01);
    for (n = 0; n < 8; n++) begin
      @(negedge sys_clk);
      if (clr === 1'b1) nclr++;
      if (fg_run === 1'b1 || done === 1'b1) break;
    end
    chk(nclr, 1);
    chk({27'h0, cfg}, {27'h0, ecfg});
    chk_bit(fg_run, ecfg[4]);
    if (ecfg[4]) begin
      @(posedge sys_clk);
      fg_done <= 1'b1;
      @(posedge sys_clk);
      fg_done <= 1'b0;
      repeat (3) @(negedge sys_clk);
    end
    chk_bit(done, 1'b1);
    chk_bit(bg_run, ecfg[3]);
    chk_bit(fg_run, 1'b0);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rreg({IDX_RUN, 2'b00}, RST_RUN);
    rreg({IDX_MODE, 2'b00}, RST_MODE);
    rreg({IDX_REF, 2'b00}, RST_REF);
    chk_bit(eng_rst, 1'b0);
    chk_bit(div_rst, 1'b0);
    chk({27'h0, cfg}, 32'h10);
    $display("test reset done");
  endtask

  task automatic t_hold();
    wreg(IDX_RUN, 8'h00);
    @(negedge sys_clk);
    chk_bit(eng_rst, 1'b1);
    chk_bit(div_rst, 1'b1);
    repeat (2) @(negedge sys_clk);
    chk({28'h0, clr, fg_run, bg_run, done}, 32'h0);
    $display("test hold done");
  endtask

  // mode and reference table: every bit set and cleared, offset enables gated
  task automatic t_modes();
    logic [7:0] mode [4] = '{8'h0F, 8'h0C, 8'h02, 8'h01};
    logic [7:0] rsel [4] = '{8'h05, 8'h01, 8'h05, 8'h01};
    logic [4:0] ecfg [4] = '{5'h1F, 5'h00, 5'h09, 5'h10};
    for (int i = 0; i < 4; i++) begin
      wreg(IDX_MODE, mode[i]);
      wreg(IDX_REF, rsel[i]);
      rreg({IDX_REF, 2'b00}, rsel[i]);
      run_seq(ecfg[i]);
      @(posedge sys_clk);
      link <= 1'b1;
      wreg(IDX_MODE, 8'h00);
      @(negedge sys_clk);
      chk({27'h0, cfg}, {27'h0, ecfg[i]});
      @(posedge sys_clk);
      link <= 1'b0;
      wreg(IDX_RUN, 8'h00);
      @(negedge sys_clk);
      chk_bit(bg_run, 1'b0);
    end
    $display("test modes done");
  endtask

  task automatic t_unmapped();
    logic [31:0] q;
    wreg(IDX_MODE, RST_MODE);
    rreg({8'h63, 2'b00}, 8'h00);
    rreg({IDX_RUN, 2'b01}, 8'h00);
    bus(1'b1, {IDX_RUN, 2'b10}, 8'h01, 4'hF, q);
    bus(1'b1, {IDX_RUN, 2'b00}, 8'h01, 4'hE, q);
    rreg({IDX_RUN, 2'b00}, 8'h00);
    chk_bit(eng_rst, 1'b1);
    run_seq(5'h10);
    $display("test unmapped done");
  endtask

  // link left on while the run bit drops: the order fault sticks until cleared
  task automatic t_fault();
    @(posedge sys_clk);
    link <= 1'b1;
    wreg(IDX_RUN, 8'h00);
    rreg({IDX_STAT, 2'b00}, 8'h02);
    @(posedge sys_clk);
    link <= 1'b0;
    wreg(IDX_STAT, 8'h02);
    rreg({IDX_STAT, 2'b00}, 8'h00);
    $display("test fault done");
  endtask

  // ==========================================================================
  // closing task, main sequence and watchdog
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    {rd, wr, link, fg_done} = 4'h0;
    addr = 10'h000;
    wdata = 32'h0;
    be = 4'h0;
    err_count = 0;
    checks = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_hold();
    t_modes();
    t_unmapped();
    t_fault();
    end_of_test();
  end

  // the tests need some two hundred cycles; a hang runs out well past that
  initial begin
    #40000;
    err_count++;
    end_of_test();
  end

endmodule

`default_nettype wire
